// [rtl/mbpga_regs.sv]
// APB register slice: headphone/debounce, mic bias and mic gain.
// Assumes APB master on pclk; headset inputs come from pins.
`timescale 1ns/1ps
//
// Behaviour
// - Debounce tick period equals selected debounce time divided by eight.
// - Bias bit 7 enables software power down; resets to zero.
// - Bias bit 3 clear: bias off when detect enabled and no headset.
// - Bias level 00 off, 01 2V, 10 2.5V, 11 supply rail.
// - Gain top bit set forces 0 dB; resets set.
// - Gain code steps 0.5 dB up to code 119; resets zero.
module mbpga_regs (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Headset status pins
  input  wire logic                 headset_detect_en,
  input  wire logic                 headset_present,
  // Analog controls
  output mbpga_pkg::mbpga_ctrl_t    ctrl,
  output logic                      dbnc_tick
);

  logic [7:0] hp_q;
  logic [7:0] hp_d;
  logic [7:0] bias_q;
  logic [7:0] bias_d;
  logic [7:0] gain_q;
  logic [7:0] gain_d;
  logic [2:0] hs_sync_q;
  logic [2:0] hs_sync_d;
  logic       hs_q;
  logic       hs_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        err_q;
  logic        err_d;
  logic        bias_on;
  mbpga_pkg::mbpga_ctrl_t ctrl_q;
  mbpga_pkg::mbpga_ctrl_t ctrl_d;

  // Word index decode, used by read and write paths
  function automatic logic idx_hit(input logic [11:0] a, input logic [7:0] idx);
    idx_hit = (a[1:0] == 2'b00) && (a[11:2] == {2'b00, idx});
  endfunction : idx_hit

  logic setup;
  logic wr_en;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pstrb[0];

  // One decode per register, shared by the write and read paths
  logic       hit_hp;
  logic       hit_rsvd;
  logic       hit_bias;
  logic       hit_gain;
  logic       hit_stat;
  assign hit_hp   = idx_hit(paddr, mbpga_pkg::IDX_HP_DEBOUNCE);
  assign hit_rsvd = idx_hit(paddr, mbpga_pkg::IDX_RSVD_AFTER);
  assign hit_bias = idx_hit(paddr, mbpga_pkg::IDX_MIC_BIAS);
  assign hit_gain = idx_hit(paddr, mbpga_pkg::IDX_MIC_GAIN);
  assign hit_stat = idx_hit(paddr, mbpga_pkg::IDX_BIAS_STATE);

  // Write strobes; reserved and status words get none, so writes there drop
  logic       wr_hp;
  logic       wr_bias;
  logic       wr_gain;
  assign wr_hp   = wr_en && hit_hp;
  assign wr_bias = wr_en && hit_bias;
  assign wr_gain = wr_en && hit_gain;

  // Always ready: answer in the first access cycle
  assign pready = 1'b1;
  assign pslverr = err_q;
  assign prdata = rdata_q;

  // Write path; unused bits kept zero regardless of what is written
  always_comb
  begin
    hp_d = hp_q;
    bias_d = bias_q;
    gain_d = gain_q;
    if (wr_hp)
    begin
      hp_d = pwdata[7:0] & mbpga_pkg::HP_WMASK;
    end
    if (wr_bias)
    begin
      bias_d = pwdata[7:0] & mbpga_pkg::BIAS_WMASK;
    end
    if (wr_gain)
    begin
      // Reserved codes are clamped so the amplifier never sees them
      gain_d[7] = pwdata[7];
      gain_d[6:0] = (pwdata[6:0] > mbpga_pkg::GAIN_MAX) ? mbpga_pkg::GAIN_MAX
                                                          : pwdata[6:0];
    end
  end

  // Reads are captured in the setup cycle so data is ready at access
  always_comb
  begin
    rdata_d = rdata_q;
    err_d = 1'b0;
    if (setup)
    begin
      rdata_d = 32'h0000_0000;
      if (hit_hp)
      begin
        rdata_d[7:0] = hp_q;
      end
      else if (hit_rsvd)
      begin
        rdata_d[7:0] = 8'h00;  // Writes here are dropped
      end
      else if (hit_bias)
      begin
        rdata_d[7:0] = bias_q;
      end
      else if (hit_gain)
      begin
        rdata_d[7:0] = gain_q;
      end
      else if (hit_stat)
      begin
        if (pwrite)
        begin
          err_d = 1'b1;  // Status word is read only
        end
        rdata_d[0] = ctrl_q.bias_on;
        rdata_d[2:1] = ctrl_q.bias_level;
      end
      else
      begin
        err_d = 1'b1;
      end
    end
    else if (psel && penable)
    begin
      err_d = err_q;
    end
  end

  // Headset presence: three flops, change once stages two and three agree
  assign hs_sync_d[0] = headset_present;
  // Stage k copies stage k-1; only stage one ever sees the raw pin
  for (genvar k = 1; k < 3; k++)
  begin : g_sync
    assign hs_sync_d[k] = hs_sync_q[k - 1];
  end

  // Presence only moves once the last two stages agree
  always_comb
  begin
    hs_d = hs_q;
    if (hs_sync_q[1] == hs_sync_q[2])
    begin
      hs_d = hs_sync_q[2];
    end
  end

  // Bias gating by headset state
  assign bias_on = (bias_q[1:0] != 2'b00) &&
                   (bias_q[mbpga_pkg::BIAS_FORCE_BIT] || !headset_detect_en || hs_q);

  // Analog control word
  always_comb
  begin
    ctrl_d.sw_power_down = bias_q[mbpga_pkg::BIAS_SWPD_BIT];
    ctrl_d.bias_level = bias_on ? mbpga_pkg::mbpga_bias_t'(bias_q[1:0])
                                : mbpga_pkg::MBPGA_BIAS_OFF;
    ctrl_d.bias_on = bias_on;
    // Override pins the gain at code zero, i.e. 0 dB
    ctrl_d.gain_half_db = gain_q[mbpga_pkg::GAIN_ZERO_BIT] ? 7'h00
                                                           : gain_q[6:0];
  end

  // Software-visible registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hp_q <= mbpga_pkg::HP_RESET;
      bias_q <= mbpga_pkg::BIAS_RESET;
      gain_q <= mbpga_pkg::GAIN_RESET;
    end
    else
    begin
      hp_q <= hp_d;
      bias_q <= bias_d;
      gain_q <= gain_d;
    end
  end

  // Synchroniser and settled presence; reset means no headset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hs_sync_q <= 3'h0;
      hs_q <= 1'b0;
    end
    else
    begin
      hs_sync_q <= hs_sync_d;
      hs_q <= hs_d;
    end
  end

  // Read answer, held from setup through the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  // Analog controls: registered so the pins never see decode glitches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
    end
  end

  assign ctrl = ctrl_q;

  // Debounce tick from headphone register bits 7..5
  mbpga_dbnc_tick u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .sel     (hp_q[mbpga_pkg::HP_DBNC_LSB +: 3]),
    .tick    (dbnc_tick)
  );

endmodule : mbpga_regs

// [rtl/mbpga_pkg.sv]
// Package for the mic bias and amplifier gain register slice.
// Assumes a 32-bit APB slave on pclk, one register per aligned word.
package mbpga_pkg;

  // Printed offsets are not multiples of four: they are word indexes
  localparam logic [7:0] IDX_HP_DEBOUNCE = 8'h2c;
  localparam logic [7:0] IDX_RSVD_AFTER  = 8'h2d;
  localparam logic [7:0] IDX_MIC_BIAS    = 8'h2e;
  localparam logic [7:0] IDX_MIC_GAIN    = 8'h2f;
  localparam logic [7:0] IDX_BIAS_STATE  = 8'h30;

  // Field positions
  localparam int BIAS_SWPD_BIT   = 7;
  localparam int BIAS_FORCE_BIT  = 3;
  localparam int GAIN_ZERO_BIT   = 7;
  localparam int HP_DBNC_LSB     = 5;

  // Writable masks and reset values
  localparam logic [7:0] BIAS_WMASK  = 8'h8b;
  localparam logic [7:0] HP_WMASK    = 8'hfe;
  localparam logic [7:0] BIAS_RESET  = 8'h00;
  localparam logic [7:0] GAIN_RESET  = 8'h80;
  localparam logic [7:0] HP_RESET    = 8'h00;
  localparam logic [6:0] GAIN_MAX    = 7'h77;

  // Debounce tick: period is debounce time / 8; select 1 is 8 us at 50 MHz
  localparam int DBNC_TICKS_PER_STEP = 8;
  localparam int CLK_MHZ             = 50;
  localparam int DBNC_BASE_US        = 8;
  localparam int DBNC_BASE_CYC       = DBNC_BASE_US * CLK_MHZ / DBNC_TICKS_PER_STEP;

  // Bias level encodings
  typedef enum logic [1:0] {
    MBPGA_BIAS_OFF  = 2'b00,
    MBPGA_BIAS_2V0  = 2'b01,
    MBPGA_BIAS_2V5  = 2'b10,
    MBPGA_BIAS_ANALOG_SUPPLY_RAIL = 2'b11
  } mbpga_bias_t;

  // Analog-facing control bundle
  typedef struct packed {
    logic        sw_power_down;
    mbpga_bias_t bias_level;
    logic        bias_on;
    logic [6:0]  gain_half_db;
  } mbpga_ctrl_t;

endpackage : mbpga_pkg

// [rtl/mbpga_dbnc_tick.sv]
// Debounce clock tick generator.
// Assumes pclk at 50 MHz; sel picks duration 0,8,...,512 us.
`timescale 1ns/1ps
module mbpga_dbnc_tick (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic [2:0] sel,
  // Tick out
  output logic            tick
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [15:0] limit;
  logic        tick_q;
  logic        tick_d;

  // Period = (8 << (sel-1)) us / 8 in cycles
  always_comb
  begin
    limit = 16'(mbpga_pkg::DBNC_BASE_CYC) << (sel - 3'd1);
    cnt_d = cnt_q + 16'h0001;
    tick_d = 1'b0;
    if (sel == 3'd0)
    begin
      cnt_d = 16'h0000;  // Zero duration: no tick at all
    end
    else if (cnt_q >= limit - 16'h0001)
    begin
      cnt_d = 16'h0000;
      tick_d = 1'b1;
    end
  end

  // Registers only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;

endmodule : mbpga_dbnc_tick

// [bench/mbpga_regs_chk.sv]
// Checker for the mic bias and gain register slice, bound to mbpga_regs.
// Assumes APB on pclk; sees only the ports of the top module.
`timescale 1ns/1ps
module mbpga_regs_chk (
  // Clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // APB
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [3:0]            pstrb,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // Analog controls
  input wire mbpga_pkg::mbpga_ctrl_t ctrl,
  input wire logic                  dbnc_tick
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access and write qualifiers
  wire logic acc = psel & penable;
  wire logic wr  = acc & pwrite & pstrb[0];

  a_ready_always: assert property (acc |-> pready) else $error("pready low in access");
  a_read_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  a_status_ro: assert property (wr && paddr == 12'h0c0 |-> pslverr) else $error("status write ok");
  a_reset_ctrl: assert property ($rose(presetn) |-> ctrl == '0)
    else $error("controls not cleared by reset");
  a_swpd_follow: assert property (wr && paddr == 12'h0b8 |-> ##2
    ctrl.sw_power_down == $past(pwdata[7], 2)) else $error("power down bit wrong");
  a_level_follow: assert property (wr && paddr == 12'h0b8 |-> ##2
    ctrl.bias_level == (ctrl.bias_on ? $past(pwdata[1:0], 2) : 2'b00))
    else $error("bias level wrong");
  a_level_off: assert property (ctrl.bias_on |-> ctrl.bias_level != 2'b00)
    else $error("bias on at level zero");
  a_gain_zero: assert property (wr && paddr == 12'h0bc && pwdata[7] |-> ##2
    ctrl.gain_half_db == 7'h00) else $error("gain not forced to zero");
  a_gain_code: assert property (wr && paddr == 12'h0bc && !pwdata[7] &&
    pwdata[6:0] <= 7'h77 |-> ##2 ctrl.gain_half_db == $past(pwdata[6:0], 2))
    else $error("gain code not applied");
  a_tick_pulse: assert property (dbnc_tick |=> !dbnc_tick) else $error("tick wider");
  a_tick_off: assert property (wr && paddr == 12'h0b0 && pwdata[7:5] == 3'h0
    |-> ##3 !dbnc_tick [*8]) else $error("tick with debounce off");
endmodule : mbpga_regs_chk

bind mbpga_regs mbpga_regs_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctrl(ctrl), .dbnc_tick(dbnc_tick));

// [bench/mbpga_regs_test.sv]
// Self-checking bench for mbpga_regs.
// Assumes the bench alone drives the APB and headset pins.
`timescale 1ns/1ps
module mbpga_regs_test;
  logic                    pclk = 1'b0;
  logic                    presetn = 1'b0;
  logic                    psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]             paddr = 12'h000;
  logic [31:0]             pwdata = 32'h0000_0000;
  logic [3:0]              pstrb = 4'hf;
  logic [31:0]             prdata;
  logic                    pready, pslverr, dbnc_tick;
  logic                    det = 1'b0, pres = 1'b0;
  mbpga_pkg::mbpga_ctrl_t  ctrl;
  logic [32:0]             q[$];
  logic [32:0]             e;
  logic [6:0]              g;
  logic                    on_x;
  int                      n_mismatch = 0, check_count = 0, n;

  mbpga_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .headset_detect_en(det), .headset_present(pres),
    .ctrl(ctrl), .dbnc_tick(dbnc_tick));

  always #10 pclk = ~pclk;

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; the edge first keeps back-to-back calls race free
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] x);
    @(posedge pclk);
    q.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Cycles between two ticks, skipping the first uneven gap
  task automatic gap(output int c);
    repeat (2) @(posedge pclk iff dbnc_tick === 1'b1);
    c = 0;
    do begin @(posedge pclk); c++; end while (dbnc_tick !== 1'b1 && c < 2000);
  endtask : gap

  // Monitor: oldest note against each finished access
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1)
    begin
      e = q.pop_front();
      check(32'(pslverr), 32'(e[32]));
      if (!pwrite)
        check(prdata, e[31:0]);
    end

  initial
  begin
    #1ms;
    n_mismatch++;
    stop_test();
  end

  initial
  begin
    void'($urandom(59));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(32'(ctrl), 32'h0000_0000);
    apb(0, 12'h0b0, 0, 33'h0);
    apb(0, 12'h0b8, 0, 33'h0);
    apb(0, 12'h0bc, 0, 33'h80);
    apb(0, 12'h0b4, 0, 33'h0); // reserved word is only ever read
    apb(0, 12'h0c4, 0, {1'b1, 32'h0});
    apb(1, 12'h0c0, 1, {1'b1, 32'h0});
    apb(1, 12'h0b8, 32'h0000_008b, 0);
    apb(0, 12'h0b8, 0, 33'h8b);
    // Every level, force, power down and detect setting; presence random
    for (int i = 0; i < 32; i++)
    begin
      det <= i[4];
      pres <= 1'($urandom_range(1, 0));
      apb(1, 12'h0b8, {24'h0, i[3], 3'h0, i[2], 1'b0, i[1:0]}, 0);
      repeat (6) @(posedge pclk);
      on_x = (i[1:0] != 0) && (i[2] || !i[4] || pres);
      check(32'(ctrl.bias_level), on_x ? 32'(i[1:0]) : 32'h0);
      check(32'(ctrl.sw_power_down), 32'(i[3]));
      check(32'(ctrl.bias_on), 32'(on_x));
    end
    // Last setting is level 11 with force set: status shows it on
    apb(0, 12'h0c0, 0, 33'h7);
    // Gain codes: top, bottom, random, then the 0 dB override
    for (int i = 0; i < 12; i++)
    begin
      n = (i == 0) ? 119 : (i == 1) ? 0 : $urandom_range(119, 0);
      g = (n > 119) ? 7'h77 : 7'(n);
      apb(1, 12'h0bc, {24'h0, i >= 10, 7'(n)}, 0);
      apb(0, 12'h0bc, 0, {25'h0, i >= 10, g});
      repeat (2) @(posedge pclk);
      check(32'(ctrl.gain_half_db), (i >= 10) ? 32'h0 : 32'(g));
    end
    // Debounce select 1 and 3, bit 0 kept zero
    for (int s = 1; s < 4; s += 2)
    begin
      apb(1, 12'h0b0, 32'(s * 32), 0);
      apb(0, 12'h0b0, 0, 33'(s * 32));
      gap(n);
      check(32'(n), 32'(mbpga_pkg::DBNC_BASE_CYC << (s - 1)));
    end
    apb(1, 12'h0b0, 0, 0);
    repeat (12) @(posedge pclk);
    stop_test();
  end
endmodule : mbpga_regs_test
